/* File: fpbc_pkg.sv */
// Shared constants and carrier types of the flyback protection and burst block.
package fpbc_pkg;

   // Clock rate of the sequencing logic.
   localparam int unsigned CLK_MHZ = 25;

   // Maximum MOSFET on-time; a longest time, so the count rounds down.
   localparam int unsigned MAX_ON_NS = 55000;
   localparam int unsigned MAX_ON_CYC = (MAX_ON_NS * CLK_MHZ) / 1000;

   // Internal protection tick of one millisecond.
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYC_DEF = TICK_US * CLK_MHZ;

   // Fault filter: low must last this many whole ticks, giving 2 to 3 ms.
   localparam int unsigned FLT_MIN_MS = 2;
   localparam int unsigned FLT_MAX_MS = 4;
   localparam logic [2:0] FILTER_TICKS = 3'h3;

   // Restart wait in ticks; plain default.
   localparam int unsigned RESTART_TICKS_DEF = 100;

   // Soft start: fifteen equal steps over the soft-start interval.
   localparam int unsigned SS_TIME_US = 3700;
   localparam logic [3:0] SS_STEPS = 4'hF;
   localparam int unsigned SS_STEP_CYC_DEF = (SS_TIME_US * CLK_MHZ) / 15;

   // Optocurrent levels in microamperes.
   localparam logic [7:0] OPTO_REG_UA = 8'h50;
   localparam logic [7:0] OPTO_FAST_DELTA_UA = 8'h14;
   localparam logic [7:0] OPTO_RESUME_UA = 8'h64;
   localparam logic [7:0] OPTO_HALT_UA = 8'hC8;
   localparam logic [7:0] OPTO_ENTRY_DEF = 8'h96;

   // Offset integrator update interval and fast-mode gain shift.
   localparam int unsigned INTEG_CYC_DEF = 25000;
   localparam int unsigned FAST_SHIFT = 4;

   // Burst target period in cycles; plain default.
   localparam int unsigned BURST_TARGET_DEF = 125000;

   // Burst pulse count limits.
   localparam logic [7:0] BURST_N_MIN = 8'h01;
   localparam logic [7:0] BURST_N_MAX = 8'hFF;

   // Comparator levels arriving from the analog front end.
   typedef struct packed {
      logic fault_low;
      logic hot;
      logic cool;
      logic mains_ok;
      logic pins_ready;
      logic out_in_reg;
   } fpbc_pins_t;

   // Enables towards the analog supply and pin circuits.
   typedef struct packed {
      logic drain_sink_en;
      logic fault_src_en;
      logic fb_src_en;
      logic ss_charge_en;
      logic vcc_reg_en;
   } fpbc_supply_t;

endpackage

/* File: fpbc_soft_start.sv */
// Stepped peak-current ramp used at every start and restart.
`timescale 1ns/10ps
module fpbc_soft_start #(
   parameter int unsigned STEP_CYC = fpbc_pkg::SS_STEP_CYC_DEF
) (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Control.
   input wire logic start_i,
   // Ramp state.
   output logic [3:0] step_o,
   output logic done_o
);
   import fpbc_pkg::*;

   localparam int unsigned CW = $clog2(STEP_CYC + 1);
   localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYC - 1);

   logic [CW-1:0] cnt_q;
   logic [3:0] step_q;
   logic run_q;

   // A start restarts the ramp from zero; steps are equal in length.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || start_i) begin
         cnt_q <= '0;
         step_q <= 4'h0;
         run_q <= start_i;
      end else if (run_q) begin
         if (cnt_q == STEP_LAST) begin
            cnt_q <= '0;
            step_q <= step_q + 4'h1;
            run_q <= (step_q + 4'h1) != SS_STEPS;
         end else begin
            cnt_q <= cnt_q + CW'(1);
         end
      end
   end

   assign step_o = step_q;
   assign done_o = (step_q == SS_STEPS);

   // The ramp rises one step at a time, apart from the return to zero on a start.
   property p_ss_step;
      @(posedge ref_clk_i) disable iff (reset_i)
         (step_q != $past(step_q)) |-> (step_q == 4'h0) ||
            (step_q == $past(step_q) + 4'h1);
   endproperty
   a_ss_step: assert property (p_ss_step)
      else $error("soft start skipped a step");
endmodule

/* File: fpbc_top.sv */
// Protection, safe restart, optobias and burst sequencing of the controller.
`timescale 1ns/10ps

module fpbc_top #(
   parameter int unsigned TICK_CYC = fpbc_pkg::TICK_CYC_DEF,
   parameter int unsigned RESTART_TICKS = fpbc_pkg::RESTART_TICKS_DEF,
   parameter int unsigned SS_STEP_CYC = fpbc_pkg::SS_STEP_CYC_DEF,
   parameter int unsigned INTEG_CYC = fpbc_pkg::INTEG_CYC_DEF,
   parameter int unsigned BURST_TARGET = fpbc_pkg::BURST_TARGET_DEF,
   parameter logic [7:0] OPTO_ENTRY_UA = fpbc_pkg::OPTO_ENTRY_DEF
) (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Analog comparator levels, asynchronous.
   input wire fpbc_pkg::fpbc_pins_t pins_i,
   // Optocurrent sample and gate request from same-clock logic.
   input wire logic [7:0] opto_ua_i,
   input wire logic gate_req_i,
   // Gate drive.
   output logic gate_o,
   // Supply and pin enables.
   output fpbc_pkg::fpbc_supply_t supply_o,
   // Power control state.
   output logic [3:0] peak_step_o,
   output logic [15:0] power_ctrl_o,
   output logic burst_mode_o,
   output logic fast_reg_o
);
   import fpbc_pkg::*;

   typedef enum logic [2:0] {
      ST_RESTART, ST_MAINS, ST_PINS, ST_SOFT, ST_RUN
   } fpbc_state_t;

   localparam int unsigned NPIN = $bits(fpbc_pins_t);
   localparam int unsigned TW = $clog2(TICK_CYC + 1);
   localparam int unsigned RW = $clog2(RESTART_TICKS + 1);
   localparam int unsigned IW = $clog2(INTEG_CYC + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
   localparam logic [RW-1:0] RESTART_LAST = RW'(RESTART_TICKS - 1);
   localparam logic [IW-1:0] INTEG_LAST = IW'(INTEG_CYC - 1);
   localparam logic [10:0] ON_LAST = 11'(MAX_ON_CYC - 1);
   localparam logic [23:0] TARGET = 24'(BURST_TARGET);
   localparam logic [23:0] LEAVE = 24'((BURST_TARGET * 3) / 2);

   logic [NPIN-1:0] sync1_q, sync2_q;
   fpbc_pins_t pins_s;
   logic [TW-1:0] tick_cnt_q;
   logic tick;
   logic [2:0] flt_ticks_q;
   logic fault_trip, hot_q, on_trip, trip;
   fpbc_state_t state_q;
   logic [RW-1:0] wait_q;
   logic vcc_reg_q;
   logic ss_start, ss_done;
   logic [3:0] ss_step;
   logic gate_q, gate_d, switch_allow, pulse_end;
   logic [10:0] on_cnt_q;
   logic [IW-1:0] integ_cnt_q;
   logic [15:0] power_q;
   logic fast;
   logic signed [17:0] delta, power_sum;
   logic burst_q, bon_q, burst_start, burst_stop;
   logic [7:0] burst_n_q, pulse_cnt_q;
   logic [23:0] period_q, bon_cnt_q;
   logic [31:0] short_period, short_target;

   // Two flip-flops per comparator level; only the second stage is used.
   for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge ref_clk_i) begin
         if (reset_i) begin
            sync1_q[i] <= 1'b0;
            sync2_q[i] <= 1'b0;
         end else begin
            sync1_q[i] <= pins_i[i];
            sync2_q[i] <= sync1_q[i];
         end
      end
   end
   assign pins_s = fpbc_pins_t'(sync2_q);

   // Free-running one millisecond tick.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || tick) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + TW'(1);
      end
   end
   assign tick = (tick_cnt_q == TICK_LAST);

   // Fault delay counter advances on the tick while the input stays low.
   // The tick phase is random, so three ticks give between 2 and 3 ms.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || !pins_s.fault_low) begin
         flt_ticks_q <= 3'h0;
      end else if (tick && flt_ticks_q != FILTER_TICKS) begin
         flt_ticks_q <= flt_ticks_q + 3'h1;
      end
   end
   assign fault_trip = (flt_ticks_q == FILTER_TICKS);

   // Overheat is held until the cool level shows; a new hot event wins.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         hot_q <= 1'b0;
      end else if (pins_s.hot) begin
         hot_q <= 1'b1;
      end else if (pins_s.cool) begin
         hot_q <= 1'b0;
      end
   end

   // Any protection sends the sequencer into safe restart.
   assign on_trip = gate_q && (on_cnt_q == ON_LAST) && gate_req_i;
   assign trip = (state_q != ST_RESTART) &&
      (fault_trip || pins_s.hot || on_trip);

   // Start and safe-restart sequence.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_q <= ST_MAINS;
         wait_q <= '0;
      end else if (trip) begin
         state_q <= ST_RESTART;
         wait_q <= '0;
      end else begin
         unique case (state_q)
            ST_RESTART: begin
               if (wait_q != RESTART_LAST) begin
                  wait_q <= wait_q + RW'(tick);
               end else if (tick && !hot_q) begin
                  state_q <= ST_MAINS;
               end
            end
            ST_MAINS: if (pins_s.mains_ok) begin
               state_q <= ST_PINS;
            end
            ST_PINS: if (pins_s.pins_ready) begin
               state_q <= ST_SOFT;
            end
            ST_SOFT: if (ss_done) begin
               state_q <= ST_RUN;
            end
            ST_RUN: begin
            end
         endcase
      end
   end

   // Supply stays regulated from a restart until the output recovers.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || trip) begin
         vcc_reg_q <= 1'b1;
      end else if (state_q == ST_RUN && pins_s.out_in_reg) begin
         vcc_reg_q <= 1'b0;
      end
   end

   assign ss_start = (state_q == ST_PINS) && pins_s.pins_ready && !trip;

   fpbc_soft_start #(
      .STEP_CYC(SS_STEP_CYC)
   ) u_soft_start (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .start_i(ss_start),
      .step_o(ss_step),
      .done_o(ss_done)
   );

   // Gate follows the request only while switching is allowed.
   assign switch_allow = (state_q == ST_SOFT || state_q == ST_RUN) &&
      !trip && (!burst_q || bon_q);
   assign gate_d = gate_req_i && switch_allow &&
      !(gate_q && on_cnt_q == ON_LAST);
   assign pulse_end = gate_q && !gate_d;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         gate_q <= 1'b0;
         on_cnt_q <= 11'h000;
      end else begin
         gate_q <= gate_d;
         on_cnt_q <= gate_d ? on_cnt_q + 11'h001 : 11'h000;
      end
   end

   // Slow offset loop; a deficit beyond the fast delta multiplies the gain.
   // The sum is widened so that a large optocurrent cannot wrap around
   // and select the fast mode by mistake.
   assign fast = (9'(opto_ua_i) + 9'(OPTO_FAST_DELTA_UA)) <
      9'(OPTO_REG_UA);
   assign delta = fast ?
      (18'(signed'({1'b0, OPTO_REG_UA})) - 18'(signed'({1'b0, opto_ua_i})))
         <<< FAST_SHIFT :
      18'(signed'({1'b0, OPTO_REG_UA})) - 18'(signed'({1'b0, opto_ua_i}));
   assign power_sum = 18'(signed'({2'b00, power_q})) + delta;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         integ_cnt_q <= '0;
         power_q <= 16'h0000;
      end else if (integ_cnt_q == INTEG_LAST) begin
         integ_cnt_q <= '0;
         if (state_q == ST_RUN) begin
            if (power_sum < 0) begin
               power_q <= 16'h0000;
            end else if (power_sum > 18'sh0FFFF) begin
               power_q <= 16'hFFFF;
            end else begin
               power_q <= power_sum[15:0];
            end
         end
      end else begin
         integ_cnt_q <= integ_cnt_q + IW'(1);
      end
   end

   // Burst start and stop decisions.
   assign burst_start = burst_q && !bon_q && (opto_ua_i < OPTO_ENTRY_UA);
   assign burst_stop = bon_q && ((opto_ua_i > OPTO_HALT_UA) ||
      (pulse_end && (9'(pulse_cnt_q) + 9'h001) >= 9'(burst_n_q) &&
       !(opto_ua_i < OPTO_RESUME_UA)));
   assign short_period = 32'(period_q) * 32'(burst_n_q - 8'h01);
   assign short_target = 32'(TARGET) * 32'(burst_n_q);

   // Burst mode, pulse counting and repetition period tracking.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || state_q != ST_RUN) begin
         burst_q <= 1'b0;
         bon_q <= 1'b0;
         pulse_cnt_q <= 8'h00;
         period_q <= 24'h000000;
         bon_cnt_q <= 24'h000000;
      end else if (!burst_q) begin
         if (power_q == 16'h0000 && opto_ua_i > OPTO_ENTRY_UA) begin
            burst_q <= 1'b1;
            period_q <= 24'h000000;
         end
      end else if (burst_start) begin
         bon_q <= 1'b1;
         pulse_cnt_q <= 8'h00;
         period_q <= 24'h000000;
         bon_cnt_q <= 24'h000000;
      end else begin
         if (period_q != 24'hFFFFFF) begin
            period_q <= period_q + 24'h000001;
         end
         if (bon_q) begin
            bon_cnt_q <= bon_cnt_q + 24'h000001;
            if (pulse_end) begin
               pulse_cnt_q <= pulse_cnt_q + 8'h01;
            end
            if (bon_cnt_q > LEAVE) begin
               burst_q <= 1'b0;
               bon_q <= 1'b0;
            end else if (burst_stop) begin
               bon_q <= 1'b0;
            end
         end
      end
   end

   // Pulse count per burst, adjusted once at each burst start.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         burst_n_q <= BURST_N_MIN;
      end else if (burst_start && period_q != 24'h000000) begin
         if (burst_n_q > BURST_N_MIN && short_period >= short_target) begin
            burst_n_q <= burst_n_q - 8'h01;
         end else if (period_q > TARGET && burst_n_q != BURST_N_MAX) begin
            burst_n_q <= burst_n_q + 8'h01;
         end
      end
   end

   // Outputs.
   assign gate_o = gate_q;
   assign supply_o.drain_sink_en = (state_q == ST_RESTART);
   assign supply_o.fault_src_en = (state_q >= ST_PINS);
   assign supply_o.fb_src_en = (state_q >= ST_PINS);
   assign supply_o.ss_charge_en = (state_q == ST_SOFT);
   assign supply_o.vcc_reg_en = vcc_reg_q;
   // The limit is held at zero outside soft start and run, so every restart is
   // seen to ramp up from the bottom again.
   assign peak_step_o = (state_q == ST_RUN) ? SS_STEPS :
      (state_q == ST_SOFT) ? ss_step : 4'h0;
   assign power_ctrl_o = power_q;
   assign burst_mode_o = burst_q;
   assign fast_reg_o = fast;

   // Checks.
   property p_stop;
      @(posedge ref_clk_i) disable iff (reset_i)
         (state_q == ST_RESTART) |=> !gate_q;
   endproperty
   a_stop: assert property (p_stop)
      else $error("gate active during restart");

   property p_filter;
      @(posedge ref_clk_i) disable iff (reset_i)
         $rose(fault_trip) |-> $past(tick) && $past(pins_s.fault_low);
   endproperty
   a_filter: assert property (p_filter)
      else $error("fault taken without filter tick");

   property p_hot_hold;
      @(posedge ref_clk_i) disable iff (reset_i)
         (state_q == ST_RESTART && hot_q) |=> state_q == ST_RESTART;
   endproperty
   a_hot_hold: assert property (p_hot_hold)
      else $error("restart left while still hot");

   property p_max_on;
      @(posedge ref_clk_i) disable iff (reset_i)
         gate_q[*8] |-> on_cnt_q >= 11'h008 && on_cnt_q <= ON_LAST;
   endproperty
   a_max_on: assert property (p_max_on)
      else $error("on-time count out of range");

   property p_on_trip;
      @(posedge ref_clk_i) disable iff (reset_i)
         on_trip |=> state_q == ST_RESTART && !gate_q;
   endproperty
   a_on_trip: assert property (p_on_trip)
      else $error("overlong on-time did not restart");

   property p_drain;
      @(posedge ref_clk_i) disable iff (reset_i)
         trip |=> supply_o.drain_sink_en && vcc_reg_q;
   endproperty
   a_drain: assert property (p_drain)
      else $error("restart without drain and regulation");

   property p_src;
      @(posedge ref_clk_i) disable iff (reset_i)
         $rose(supply_o.fault_src_en) |-> $past(pins_s.mains_ok);
   endproperty
   a_src: assert property (p_src)
      else $error("sources enabled without mains");

   property p_power_dn;
      @(posedge ref_clk_i) disable iff (reset_i)
         (integ_cnt_q == INTEG_LAST && state_q == ST_RUN &&
          opto_ua_i > OPTO_REG_UA && power_q != 16'h0000)
            |=> power_q < $past(power_q);
   endproperty
   a_power_dn: assert property (p_power_dn)
      else $error("excess optocurrent did not lower power");

   property p_halt;
      @(posedge ref_clk_i) disable iff (reset_i)
         (bon_q && opto_ua_i > OPTO_HALT_UA && state_q == ST_RUN &&
          bon_cnt_q <= LEAVE)
            |=> !bon_q ##1 !gate_q;
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt level did not stop burst");

   property p_min_n;
      @(posedge ref_clk_i) disable iff (reset_i)
         burst_n_q >= BURST_N_MIN;
   endproperty
   a_min_n: assert property (p_min_n)
      else $error("burst pulse count below one");

   property p_leave;
      @(posedge ref_clk_i) disable iff (reset_i)
         (bon_q && bon_cnt_q > LEAVE) |=> !burst_q;
   endproperty
   a_leave: assert property (p_leave)
      else $error("long burst did not leave burst mode");
endmodule

/* File: fpbc_opto_model.sv */
// Behavioural secondary-side feedback: optocurrent and regulation flag.
`timescale 1ns/10ps
module fpbc_opto_model (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Gate seen from the primary and demanded optocurrent.
   input wire logic gate_i,
   input wire logic [7:0] demand_ua_i,
   // Feedback towards the primary.
   output logic [7:0] opto_ua_o,
   output logic out_in_reg_o
);
   logic gate_q;
   logic [2:0] pulses_q;

   // The optocurrent follows the demand one edge later, like a sensor.
   always_ff @(posedge ref_clk_i) begin
      opto_ua_o <= demand_ua_i;
   end

   // The output counts as regulated only after four delivered pulses; a
   // reset drops it, but a safe restart without reset keeps a regulated output.
   always_ff @(posedge ref_clk_i) begin
      gate_q <= gate_i;
      if (reset_i) begin
         pulses_q <= 3'h0;
      end else if (gate_i && !gate_q && pulses_q != 3'h4) begin
         pulses_q <= pulses_q + 3'h1;
      end
   end

   // Level seen by the primary's comparator.
   assign out_in_reg_o = (pulses_q == 3'h4);
endmodule

/* File: flyback_protect_burst_control_tb.sv */
// Self-checking bench of the flyback protection and burst sequencing block.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
   num_checks++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
   end \
end
`define WAITC(c, n) for (i = 0; i < (n) && (c) !== 1'b1; i++) cyc(1);
module flyback_protect_burst_control_tb;
   import fpbc_pkg::*;
   typedef struct {
      logic [7:0] o;
      logic f;
   } fpbc_row_t;
   // Shortened counts keep the run brief; expectations follow these values.
   localparam int unsigned TICK = 20;
   localparam int unsigned RST_T = 3;
   localparam int unsigned SS_CYC = 4;
   localparam int unsigned INTEG = 8;
   localparam int unsigned TGT = 200;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic flt = 1'b0;
   logic hot = 1'b0;
   logic cool = 1'b1;
   logic mains = 1'b0;
   logic rdy = 1'b0;
   logic in_reg;
   logic [7:0] demand = 8'h50;
   logic [7:0] opto;
   logic gate_req = 1'b0;
   logic gate;
   fpbc_pins_t pins;
   fpbc_supply_t sup;
   logic [3:0] step;
   logic [15:0] power;
   logic burst;
   logic fast;
   int fail_count = 0;
   int num_checks = 0;
   int i;
   fpbc_row_t rows [5] = '{'{8'h00, 1'b1}, '{8'h3B, 1'b1},
      '{8'h3C, 1'b0}, '{8'h50, 1'b0}, '{8'hC8, 1'b0}};

   // Comparator levels in struct order, most significant first.
   assign pins = {flt, hot, cool, mains, rdy, in_reg};

   fpbc_top #(.TICK_CYC(TICK), .RESTART_TICKS(RST_T), .SS_STEP_CYC(SS_CYC),
      .INTEG_CYC(INTEG), .BURST_TARGET(TGT)) u_dut (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .pins_i(pins),
      .opto_ua_i(opto), .gate_req_i(gate_req), .gate_o(gate),
      .supply_o(sup), .peak_step_o(step), .power_ctrl_o(power),
      .burst_mode_o(burst), .fast_reg_o(fast));

   fpbc_opto_model u_opto (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .gate_i(gate), .demand_ua_i(demand), .opto_ua_o(opto),
      .out_in_reg_o(in_reg));

   // 25 MHz clock.
   initial begin
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask

   // Reset is held twelve cycles so the synchronisers are flushed too.
   task automatic do_reset();
      reset_i = 1'b1;
      mains = 1'b0;
      rdy = 1'b0;
      cyc(12);
      reset_i = 1'b0;
   endtask

   // Mains, then pin readiness, then the stepped ramp into run.
   task automatic bring_up();
      mains = 1'b1;
      `WAITC(sup.fault_src_en, 20)
      `CHK("src_on", 1'b1, sup.fb_src_en)
      rdy = 1'b1;
      cyc(40);
      `CHK("ss_charge", 1'b1, sup.ss_charge_en)
      `CHK("ramp_early", 1'b1, step != 4'hF)
      `WAITC(step == 4'hF, 15 * SS_CYC + 20)
      `CHK("ramp_top", 4'hF, step)
   endtask

   task automatic results();
      if (fail_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // A hang is cut well after the expected length of the run.
   initial begin
      cyc(20000);
      fail_count++;
      results();
   end

   initial begin
      do_reset();
      `CHK("vcc_reset", 1'b1, sup.vcc_reg_en)
      `CHK("src_reset", 1'b0, sup.fault_src_en)
      `CHK("power_reset", 16'h0000, power)
      `CHK("burst_reset", 1'b0, burst)
      // Fast-mode selection as a plain table of levels.
      foreach (rows[k]) begin
         demand = rows[k].o;
         cyc(2);
         `CHK("fast_mode", rows[k].f, fast)
      end
      demand = 8'h50;
      bring_up();
      // Four delivered pulses bring the output into regulation.
      repeat (4) begin
         gate_req = 1'b1;
         cyc(2);
         `CHK("gate_run", 1'b1, gate)
         gate_req = 1'b0;
         cyc(2);
      end
      cyc(6);
      `CHK("vcc_release", 1'b0, sup.vcc_reg_en)
      // Burst entry, pause, restart, halt, immediate start and exit.
      demand = 8'hA0;
      cyc(4);
      `CHK("burst_entry", 1'b1, burst)
      gate_req = 1'b1;
      cyc(3);
      `CHK("burst_pause", 1'b0, gate)
      demand = 8'h5A;
      cyc(4);
      `CHK("burst_start", 1'b1, gate)
      demand = 8'hD2;
      cyc(3);
      `CHK("burst_halt", 1'b0, gate)
      demand = 8'h32;
      cyc(4);
      `CHK("burst_resume", 1'b1, gate)
      cyc(10);
      `CHK("burst_keep", 1'b1, gate)
      `WAITC(burst == 1'b0, 2 * TGT)
      `CHK("burst_exit", 1'b0, burst)
      gate_req = 1'b0;
      // Offset integrator: fast steps, slow steps, saturation at zero.
      do_reset();
      bring_up();
      demand = 8'h28;
      cyc(3 * INTEG);
      `CHK("integ_fast", 1'b1, power != 0 && power % 640 == 0)
      demand = 8'h46;
      cyc(2 * INTEG);
      `CHK("integ_slow", 1'b1, power % 640 != 0 && power % 10 == 0)
      demand = 8'hC8;
      cyc(30 * INTEG);
      `CHK("integ_floor", 16'h0000, power)
      // Filtered fault input, then restart gated by mains.
      do_reset();
      demand = 8'h50;
      bring_up();
      gate_req = 1'b1;
      flt = 1'b1;
      cyc(38);
      `CHK("flt_filter", 1'b0, sup.drain_sink_en)
      `WAITC(sup.drain_sink_en, 2 * TICK)
      `CHK("flt_trip", 1'b1, sup.drain_sink_en)
      `CHK("flt_gate", 1'b0, gate)
      flt = 1'b0;
      mains = 1'b0;
      gate_req = 1'b0;
      cyc(30);
      `CHK("rst_wait", 1'b1, sup.drain_sink_en)
      cyc(120);
      `CHK("rst_brownin", 1'b0, sup.fault_src_en)
      `CHK("rst_done", 1'b0, sup.drain_sink_en)
      mains = 1'b1;
      `WAITC(sup.fault_src_en, 10)
      `CHK("rst_src", 1'b1, sup.fault_src_en)
      `WAITC(step == 4'hF, 15 * SS_CYC + 20)
      `CHK("rst_ramp", 4'hF, step)
      // Pulses bring the output into regulation so the trip must re-arm it.
      repeat (4) begin
         gate_req = 1'b1;
         cyc(2);
         gate_req = 1'b0;
         cyc(2);
      end
      cyc(4);
      `CHK("ton_pre", 1'b0, sup.vcc_reg_en)
      // Overlong on-time forces a safe restart.
      gate_req = 1'b1;
      cyc(1300);
      `CHK("ton_ok", 1'b1, gate)
      `WAITC(sup.drain_sink_en, 100)
      `CHK("ton_trip", 1'b1, sup.drain_sink_en)
      `CHK("ton_gate", 1'b0, gate)
      `CHK("ton_vcc", 1'b1, sup.vcc_reg_en)
      gate_req = 1'b0;
      `WAITC(step == 4'hF, (RST_T + 2) * TICK + 15 * SS_CYC + 20)
      `CHK("ton_back", 4'hF, step)
      // Overheat holds off the restart until the die has cooled.
      hot = 1'b1;
      cool = 1'b0;
      `WAITC(sup.drain_sink_en, 10)
      `CHK("hot_trip", 1'b1, sup.drain_sink_en)
      cyc(200);
      `CHK("hot_hold", 1'b0, sup.fault_src_en)
      hot = 1'b0;
      cyc(20);
      `CHK("hot_hyst", 1'b0, sup.fault_src_en)
      cool = 1'b1;
      `WAITC(sup.fault_src_en, TICK + 10)
      `CHK("hot_resume", 1'b1, sup.fault_src_en)
      results();
   end
endmodule
